// file: core/sjt_tap.sv
`timescale 1ns/1ps
module sjt_tap
  import sjt_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = 32'h00000001 // arbitrary value, bit 0 set for presence
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  input wire logic [BSR_W-1:0] PIN_SNAPSHOT,
  output logic TDO,
  output logic TDO_OE_N,
  output logic [BSR_W-1:0] BSR_PARALLEL,
  output logic EXTEST_ACTIVE,
  output logic PORT_A_DATA_BUS_DRIVE,
  output logic PORT_B_DATA_BUS_DRIVE,
  output logic PORT_ENABLE_PIN_N_DRIVE,
  output logic SRAM_OUTPUTS_HIGHZ,
  output logic [IR_W-1:0] CURRENT_INSTR
);
  // ************************************************
  // pin synchronisers and tck edges
  // ************************************************
  sjt_pins_t pins_m, pins_s;
  logic tck_d;
  // the sram side runs on its own clock, so the snapshot is synchronised too
  logic [BSR_W-1:0] snap_m, snap_s;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pins_m <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
      pins_s <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
      tck_d <= 1'b0;
      snap_m <= '0;
      snap_s <= '0;
    end else begin
      pins_m <= '{tck: TCK, tms: TMS, tdi: TDI, trst_n: TRST_N};
      pins_s <= pins_m;
      tck_d <= pins_s.tck;
      snap_m <= PIN_SNAPSHOT;
      snap_s <= snap_m;
    end
  end
  logic tck_rise, tck_fall;
  assign tck_rise = pins_s.tck && !tck_d;
  assign tck_fall = !pins_s.tck && tck_d;

  sjt_state_t state;
  sjt_fsm u_fsm (
    .clk(CLK),
    .srst(SRST),
    .tck_rise(tck_rise),
    .tms(pins_s.tms),
    .trst_n(pins_s.trst_n),
    .state(state)
  );

  // ************************************************
  // instruction and data registers
  // ************************************************
  function automatic logic sel_bsr(input logic [IR_W-1:0] ir);
    sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLEZ) || (ir == IR_SAMPLE);
  endfunction

  logic [IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
  logic [ID_W-1:0] id_sh, next_id_sh;
  logic byp, next_byp;
  logic [BSR_W-1:0] bsr, next_bsr, upd, next_upd;
  logic out_bit, next_out_bit, tdo_q, next_tdo, oe_n, next_oe_n;
  logic sh_now;
  assign sh_now = tck_rise && (state == ST_SH_DR);

  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_id_sh = id_sh;
    next_byp = byp;
    next_bsr = bsr;
    next_upd = upd;
    if (state == ST_TLR) begin
      next_ir = IR_IDCODE;
      next_upd[BSR_OE_A] = 1'b0;
      next_upd[BSR_OE_B] = 1'b0;
    end
    if (tck_rise) begin
      case (state)
        ST_CAP_IR: next_ir_sh = {ir[IR_W-1:2], IR_CAPTURE_LSB};
        ST_SH_IR: next_ir_sh = {pins_s.tdi, ir_sh[IR_W-1:1]};
        ST_UPD_IR: next_ir = ir_sh;
        ST_CAP_DR: begin
          next_id_sh = ID_VALUE;
          next_byp = 1'b0;
          next_bsr = snap_s;
        end
        ST_SH_DR: begin
          if (ir == IR_IDCODE) begin
            next_id_sh = {pins_s.tdi, id_sh[ID_W-1:1]};
          end else if (sel_bsr(ir)) begin
            next_bsr = {pins_s.tdi, bsr[BSR_W-1:1]};
          end else begin
            next_byp = pins_s.tdi;
          end
        end
        ST_UPD_DR: if (sel_bsr(ir)) next_upd = bsr;
        default: ;
      endcase
    end
  end

  // what tdo shows next, chosen from the lsb of the selected register
  always_comb begin
    next_out_bit = ir_sh[0];
    if (state == ST_SH_DR) begin
      if (ir == IR_IDCODE) next_out_bit = id_sh[0];
      else if (sel_bsr(ir)) next_out_bit = bsr[0];
      else next_out_bit = byp;
    end
    next_tdo = tdo_q;
    next_oe_n = oe_n;
    // tdo only updates on the falling tck edge
    if (tck_fall) begin
      next_tdo = out_bit;
      next_oe_n = !((state == ST_SH_DR) || (state == ST_SH_IR));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ir_sh <= IR_IDCODE;
      ir <= IR_IDCODE;
      id_sh <= '0;
      byp <= 1'b0;
      bsr <= '0;
      upd <= '0;
      out_bit <= 1'b0;
      tdo_q <= 1'b0;
      oe_n <= 1'b1;
    end else begin
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      id_sh <= next_id_sh;
      byp <= next_byp;
      bsr <= next_bsr;
      upd <= next_upd;
      out_bit <= next_out_bit;
      tdo_q <= next_tdo;
      oe_n <= next_oe_n;
    end
  end
  assign TDO = tdo_q;
  assign TDO_OE_N = oe_n;

  // ************************************************
  // output control
  // ************************************************
  // registered copies keep every top output on a flip-flop
  logic drv_a, drv_b, hiz, ext;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      drv_a <= 1'b1;
      drv_b <= 1'b1;
      hiz <= 1'b0;
      ext <= 1'b0;
      BSR_PARALLEL <= '0;
    end else begin
      ext <= (ir == IR_EXTEST);
      hiz <= (ir == IR_SAMPLEZ);
      // high-z sample overrides every driver regardless of cells;
      // otherwise ports stay enabled unless extest holds an enable cell low
      drv_a <= (ir != IR_SAMPLEZ) && ((ir != IR_EXTEST) || upd[BSR_OE_A]);
      drv_b <= (ir != IR_SAMPLEZ) && ((ir != IR_EXTEST) || upd[BSR_OE_B]);
      BSR_PARALLEL <= upd;
    end
  end
  assign EXTEST_ACTIVE = ext;
  assign SRAM_OUTPUTS_HIGHZ = hiz;
  assign PORT_A_DATA_BUS_DRIVE = drv_a;
  assign PORT_B_DATA_BUS_DRIVE = drv_b;
  assign PORT_ENABLE_PIN_N_DRIVE = drv_a;
  assign CURRENT_INSTR = ir;

  // ************************************************
  // checks
  // ************************************************
  property p_tlr_idcode;
    @(posedge CLK) disable iff (SRST) state == ST_TLR |=> ir == IR_IDCODE;
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("ir not idcode after reset state");
  property p_tlr_oe;
    @(posedge CLK) disable iff (SRST) state == ST_TLR |=> !upd[BSR_OE_A] && !upd[BSR_OE_B];
  endproperty
  a_tlr_oe: assert property (p_tlr_oe) else $error("enable latches not cleared");
  property p_capir;
    @(posedge CLK) disable iff (SRST) (tck_rise && state == ST_CAP_IR) |=> ir_sh[1:0] == IR_CAPTURE_LSB;
  endproperty
  a_capir: assert property (p_capir) else $error("capture-ir pattern wrong");
  property p_capid;
    @(posedge CLK) disable iff (SRST) (tck_rise && state == ST_CAP_DR) |=> id_sh == ID_VALUE;
  endproperty
  a_capid: assert property (p_capid) else $error("id not captured");
  property p_capbsr;
    @(posedge CLK) disable iff (SRST) (tck_rise && state == ST_CAP_DR) |=> bsr == $past(snap_s);
  endproperty
  a_capbsr: assert property (p_capbsr) else $error("snapshot not captured");
  property p_hiz;
    @(posedge CLK) disable iff (SRST) ir == IR_SAMPLEZ |=>
      !PORT_A_DATA_BUS_DRIVE && !PORT_B_DATA_BUS_DRIVE && !PORT_ENABLE_PIN_N_DRIVE;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not high-z");
  property p_ext_oe;
    @(posedge CLK) disable iff (SRST) (ir == IR_EXTEST && $stable(ir)) |=> drv_b == $past(upd[BSR_OE_B]);
  endproperty
  a_ext_oe: assert property (p_ext_oe) else $error("enable cell not obeyed");
  property p_tdo_fall;
    @(posedge CLK) disable iff (SRST) !tck_fall |=> $stable(tdo_q);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge");
  property p_upd;
    @(posedge CLK) disable iff (SRST) (tck_rise && state == ST_UPD_DR && sel_bsr(ir)) |=> upd == $past(bsr);
  endproperty
  a_upd: assert property (p_upd) else $error("update-dr latch missed");
endmodule // sjt_tap

// file: shared/sjt_pkg.sv
package sjt_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 136;
  localparam int BSR_OE_B = 49;
  localparam int BSR_OE_A = 50;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
  localparam int TLR_ONES = 5;

  // tap controller states, gray-coded along the data-register path
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PAU_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hc,
    ST_SEL_IR = 4'hd,
    ST_CAP_IR = 4'hf,
    ST_SH_IR = 4'he,
    ST_EX1_IR = 4'ha,
    ST_PAU_IR = 4'hb,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } sjt_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } sjt_pins_t;
endpackage

// file: core/sjt_fsm.sv
`timescale 1ns/1ps
module sjt_fsm
  import sjt_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tck_rise,
  input wire logic tms,
  input wire logic trst_n,
  output sjt_state_t state
);
  sjt_state_t next_state;

  // standard sixteen-state controller
  always_comb begin
    next_state = state;
    if (!trst_n) begin
      next_state = ST_TLR;
    end else if (tck_rise) begin
      case (state)
        ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
        ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
        default: next_state = ST_TLR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  // five rising edges with tms high always reach test-logic-reset
  logic [2:0] ones;
  always_ff @(posedge clk) begin
    if (srst || !tms) begin
      ones <= 3'h0;
    end else if (tck_rise && ones != 3'h7) begin
      ones <= ones + 3'h1;
    end
  end
  property p_tms_reset;
    @(posedge clk) disable iff (srst) (ones == 3'(TLR_ONES) && trst_n) |-> state == ST_TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five tms highs did not reset tap");
endmodule // sjt_fsm

// file: testbench/sjt_ctl_model.sv
`timescale 1ns/1ps
module sjt_ctl_model
  import sjt_pkg::*;
(
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  output sjt_pins_t pins
);
  // ****************
  // scan controller
  // ****************
  logic d;
  logic shift_oe;
  initial begin
    pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
    shift_oe = 1'b0;
  end
  // change on the fall, hold over the rise; tdo is read as tck rises
  task automatic tick(input logic tms, input logic tdi, output logic q);
    pins.tck <= 1'b0;
    pins.tms <= tms;
    pins.tdi <= tdi;
    repeat (4) @(posedge clk);
    pins.tck <= 1'b1;
    q = tdo;
    repeat (4) @(posedge clk);
  endtask
  // tdi toggles when unused so a stale level never looks valid
  task automatic step(input logic tms);
    tick(tms, ~pins.tdi, d);
  endtask
  task automatic reset5();
    repeat (5) step(1'b1);
    step(1'b0);
  endtask
  task automatic trst();
    @(posedge clk);
    pins.trst_n <= 1'b0;
    repeat (8) @(posedge clk);
    pins.trst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // callers never pass a reserved code
  task automatic load_ir(input logic [IR_W-1:0] code, output logic [1:0] cap);
    logic [IR_W-1:0] c;
    step(1'b1);
    step(1'b1);
    step(1'b0);
    step(1'b0);
    for (int i = 0; i < IR_W; i++) begin
      tick(i == IR_W - 1, code[i], c[i]);
    end
    step(1'b1);
    step(1'b0);
    // registered outputs follow the update a clock or two later
    repeat (2) @(posedge clk);
    cap = c[1:0];
  endtask
  task automatic scan_dr(input int n, input logic [BSR_W-1:0] din, output logic [BSR_W-1:0] dout);
    dout = '0;
    step(1'b1);
    step(1'b0);
    step(1'b0);
    shift_oe = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
      shift_oe = shift_oe && (tdo_oe_n === 1'b0);
    end
    step(1'b1);
    step(1'b0);
    repeat (2) @(posedge clk);
  endtask
endmodule // sjt_ctl_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import sjt_pkg::*;
  localparam logic [ID_W-1:0] ID_TB = 32'h2468ace1; // arbitrary value
  logic clk;
  logic srst;
  logic [BSR_W-1:0] snap;
  logic [BSR_W-1:0] pre;
  logic [BSR_W-1:0] got;
  logic [BSR_W-1:0] par;
  logic [1:0] cap;
  sjt_pins_t pins;
  logic tdo;
  logic tdo_oe_n;
  logic ext;
  logic a_drv;
  logic b_drv;
  logic pe_drv;
  logic hiz;
  logic [IR_W-1:0] instr;
  int err_count;
  int n_tests;

  sjt_tap #(.ID_VALUE(ID_TB)) i_dut (
    .CLK(clk), .SRST(srst), .TCK(pins.tck), .TMS(pins.tms), .TDI(pins.tdi),
    .TRST_N(pins.trst_n), .PIN_SNAPSHOT(snap), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .BSR_PARALLEL(par),
    .EXTEST_ACTIVE(ext), .PORT_A_DATA_BUS_DRIVE(a_drv), .PORT_B_DATA_BUS_DRIVE(b_drv),
    .PORT_ENABLE_PIN_N_DRIVE(pe_drv), .SRAM_OUTPUTS_HIGHZ(hiz), .CURRENT_INSTR(instr)
  );
  sjt_ctl_model i_ctl (.clk(clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pins(pins));

  // ****************
  // checks
  // ****************
  task automatic chk(input logic [BSR_W-1:0] g, input logic [BSR_W-1:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [BSR_W-1:0] outs();
    return BSR_W'({hiz, a_drv, b_drv, pe_drv});
  endfunction

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  // ****************
  // tests
  // ****************
  initial begin
    srst = 1'b1;
    err_count = 0;
    n_tests = 0;
    // pins held still across every capture
    snap = {8'ha5, {4{32'h3c96e1f0}}};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(BSR_W'(instr), BSR_W'(IR_IDCODE), "ir after reset");
    chk(BSR_W'(par[BSR_OE_A:BSR_OE_B]), '0, "oe after reset");
    chk(BSR_W'(tdo_oe_n), BSR_W'(1'b1), "tdo off after reset");
    i_ctl.step(1'b0);
    i_ctl.scan_dr(ID_W, '0, got);
    chk(got, BSR_W'(ID_TB), "id shift");
    chk(outs(), BSR_W'(4'b0111), "idcode keeps ports");
    i_ctl.load_ir(IR_BYPASS, cap);
    chk(BSR_W'(cap), BSR_W'(IR_CAPTURE_LSB), "ir capture");
    chk(BSR_W'(instr), BSR_W'(IR_BYPASS), "bypass decode");
    chk(outs(), BSR_W'(4'b0111), "bypass keeps ports");
    i_ctl.scan_dr(2, BSR_W'(2'b11), got);
    chk(got, BSR_W'(2'b10), "bypass path");
    pre = ~snap;
    pre[BSR_OE_A] = 1'b1;
    pre[BSR_OE_B] = 1'b1;
    i_ctl.load_ir(IR_SAMPLE, cap);
    i_ctl.scan_dr(BSR_W, pre, got);
    chk(got, snap, "sample capture");
    chk(BSR_W'(i_ctl.shift_oe), BSR_W'(1'b1), "tdo on in shift");
    chk(BSR_W'(tdo_oe_n), BSR_W'(1'b1), "tdo off after shift");
    chk(par, pre, "preload latch");
    i_ctl.load_ir(IR_EXTEST, cap);
    chk(BSR_W'(ext), BSR_W'(1'b1), "extest decode");
    chk(outs(), BSR_W'(4'b0111), "extest drives");
    pre[BSR_OE_B] = 1'b0;
    i_ctl.scan_dr(BSR_W, pre, got);
    chk(got, snap, "extest scan");
    chk(outs(), BSR_W'(4'b0101), "port b off");
    pre[BSR_OE_A] = 1'b0;
    pre[BSR_OE_B] = 1'b1;
    i_ctl.scan_dr(BSR_W, pre, got);
    chk(outs(), BSR_W'(4'b0010), "port a off");
    i_ctl.load_ir(IR_SAMPLEZ, cap);
    chk(outs(), BSR_W'(4'b1000), "high-z sample");
    i_ctl.scan_dr(BSR_W, pre, got);
    chk(got, snap, "high-z scan");
    chk(outs(), BSR_W'(4'b1000), "high-z held");
    i_ctl.load_ir(IR_SAMPLE, cap);
    chk(outs(), BSR_W'(4'b0111), "ports back");
    i_ctl.reset5();
    chk(BSR_W'(instr), BSR_W'(IR_IDCODE), "tms reset");
    chk(BSR_W'(par[BSR_OE_A:BSR_OE_B]), '0, "oe preset");
    i_ctl.load_ir(IR_BYPASS, cap);
    i_ctl.trst();
    chk(BSR_W'(instr), BSR_W'(IR_IDCODE), "pin reset");
    print_verdict();
  end
endmodule // tb
